// ==== hw/cfbs_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the charger supervisor.
// Assumes a 25 MHz clock; included by the supervisor module.
`ifndef CFBS_CFG_SVH
`define CFBS_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CFBS_FAULT_ADDR 8'h0D
`define CFBS_CTRL_ADDR 8'h07
`define CFBS_CFG2_ADDR 8'h08
`define CFBS_STATUS_ADDR 8'h0B
`define CFBS_FLT_TSD_BIT 0
`define CFBS_FLT_WARN_BIT 1
`define CFBS_FLT_SHORT_BIT 2
`define CFBS_FLT_THROPEN_BIT 3
`define CFBS_CTRL_THR_EN_BIT 4
`define CFBS_CFG2_ZONE_EN_BIT 7
`define CFBS_CFG2_ZONE_SEL_BIT 6
`define CFBS_CTRL_RESET 8'h00
`define CFBS_CHG_FAULT_CODE 3'h6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CFBS_CLK_HZ 25000000
`define CFBS_THR_PERIOD_MS 167
`define CFBS_THR_CYCLES ((`CFBS_CLK_HZ / 1000) * `CFBS_THR_PERIOD_MS)
`define CFBS_TRICKLE_MIN 60
`define CFBS_TRICKLE_CYCLES (64'(`CFBS_CLK_HZ) * 60 * `CFBS_TRICKLE_MIN)
`define CFBS_DETECT_MS 10
`define CFBS_DETECT_CYCLES ((`CFBS_CLK_HZ / 1000) * `CFBS_DETECT_MS)
`define CFBS_SHORT_MS 30
`define CFBS_SHORT_CYCLES ((`CFBS_CLK_HZ / 1000) * `CFBS_SHORT_MS)

`endif

// ==== hw/cfbs_pkg.sv ====
// Types for the charger supervisor.
// Assumes cfbs_cfg.svh sits beside it.
package cfbs_pkg;

	// ------------------------------------------------------------------------
	// Modes
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		CFBS_IDLE,
		CFBS_SINK,
		CFBS_SOURCE,
		CFBS_TRICKLE,
		CFBS_FAST,
		CFBS_FAULT,
		CFBS_NOBAT
	} cfbs_phase_e;

	typedef enum logic [1:0] {
		CFBS_ISO_OFF,
		CFBS_ISO_REG,
		CFBS_ISO_FULL
	} cfbs_iso_e;

	typedef enum logic [2:0] {
		CFBS_Z_COLD,
		CFBS_Z_COOL,
		CFBS_Z_TYP,
		CFBS_Z_WARM,
		CFBS_Z_HOT
	} cfbs_zone_e;

	// ------------------------------------------------------------------------
	// Comparator inputs
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic die_above_sd;
		logic die_below_sd_fall;
		logic die_above_warn;
		logic supply_good;
		logic supply_in_range;
		logic bat_above_2v5;
		logic bat_above_low_detect;
		logic bat_above_high_detect;
		logic sense_above_high_detect;
		logic bat_above_dead;
		logic bat_above_sys_reg;
		logic bat_above_short;
		logic sys_below_bat;
		logic thr_open;
		logic thr_below_0c;
		logic thr_below_10c;
		logic thr_above_45c;
		logic thr_above_60c;
	} cfbs_cmp_s;

	// ------------------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic charge_en;
		logic half_current;
		logic vtrm_minus_100mv;
		logic sink_en;
		logic source_en;
		logic trickle;
		logic sys_at_trickle_level;
		logic thr_source_on;
		cfbs_iso_e iso_mode;
	} cfbs_ctl_s;

endpackage : cfbs_pkg

// ==== hw/cfbs_supervisor.sv ====
// Charger fault and battery supervisor: thermal flags, detection, isolation switch, zones.
// Assumes comparator inputs synchronous to clk_i and a byte register port (addr, wr, rd).
`timescale 1ns/1ns
`include "cfbs_cfg.svh"

module cfbs_supervisor #(
	parameter int unsigned DETECT_CYCLES = `CFBS_DETECT_CYCLES,
	parameter int unsigned SHORT_CYCLES = `CFBS_SHORT_CYCLES,
	parameter int unsigned THR_CYCLES = `CFBS_THR_CYCLES,
	parameter longint unsigned TRICKLE_CYCLES = `CFBS_TRICKLE_CYCLES,
	parameter bit ZONE_EN_PRESET = 1'b0,
	parameter bit ZONE_SEL_PRESET = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic charge_request_i,
	input wire cfbs_pkg::cfbs_cmp_s cmp_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output cfbs_pkg::cfbs_ctl_s ctl_o,
	output logic [2:0] charger_state_o
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		cfbs_pkg::cfbs_phase_e phase;
		logic [31:0] phase_cnt;
		logic [31:0] short_cnt;
		logic [31:0] thr_cnt;
		logic [37:0] trk_cnt;
		logic tsd_flag;
		logic warn_flag;
		logic short_flag;
		logic thr_open_flag;
		logic thr_en;
		logic zone_en;
		logic zone_sel;
		logic thr_phase;
		logic [7:0] rdata;
		cfbs_pkg::cfbs_ctl_s ctl;
		logic [2:0] state_code;
	} cfbs_state_s;

	cfbs_state_s s_q;
	cfbs_state_s s_d;

	logic sense_on;
	logic hot_cold;
	cfbs_pkg::cfbs_zone_e zone;
	logic fault_clear;
	logic charging;
	cfbs_pkg::cfbs_iso_e iso_base;

	// ------------------------------------------------------------------------
	// Zone and sensing decode
	// ------------------------------------------------------------------------
	always_comb begin
		fault_clear = reg_wr_i && (reg_addr_i == `CFBS_FAULT_ADDR) && (reg_wdata_i != 8'h00);
		if (cmp_i.supply_in_range) begin
			sense_on = 1'b1;
		end else begin
			sense_on = cmp_i.bat_above_2v5 && s_q.thr_en;
		end
		if (cmp_i.thr_open || cmp_i.thr_below_0c) begin
			zone = cfbs_pkg::CFBS_Z_COLD;
		end else if (cmp_i.thr_above_60c) begin
			zone = cfbs_pkg::CFBS_Z_HOT;
		end else if (cmp_i.thr_above_45c) begin
			zone = cfbs_pkg::CFBS_Z_WARM;
		end else if (cmp_i.thr_below_10c) begin
			zone = cfbs_pkg::CFBS_Z_COOL;
		end else begin
			zone = cfbs_pkg::CFBS_Z_TYP;
		end
		hot_cold = sense_on && ((zone == cfbs_pkg::CFBS_Z_COLD) || (zone == cfbs_pkg::CFBS_Z_HOT));
		charging = (s_q.phase == cfbs_pkg::CFBS_TRICKLE) || (s_q.phase == cfbs_pkg::CFBS_FAST);

		// ------------------------------------------------------------------------
		// Isolation base from cell voltage
		// ------------------------------------------------------------------------
		if (cmp_i.bat_above_sys_reg) begin
			iso_base = cfbs_pkg::CFBS_ISO_FULL;
		end else if (cmp_i.bat_above_dead) begin
			iso_base = cfbs_pkg::CFBS_ISO_REG;
		end else begin
			iso_base = cfbs_pkg::CFBS_ISO_OFF;
		end
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.phase_cnt = s_q.phase_cnt + 32'h0000_0001;

		// ------------------------------------------------------------------------
		// Fault flags: set wins over clear
		// ------------------------------------------------------------------------
		if (fault_clear && reg_wdata_i[`CFBS_FLT_TSD_BIT]) begin
			s_d.tsd_flag = 1'b0;
		end
		if (fault_clear && reg_wdata_i[`CFBS_FLT_WARN_BIT]) begin
			s_d.warn_flag = 1'b0;
		end
		if (fault_clear && reg_wdata_i[`CFBS_FLT_SHORT_BIT]) begin
			s_d.short_flag = 1'b0;
		end
		if (fault_clear && reg_wdata_i[`CFBS_FLT_THROPEN_BIT]) begin
			s_d.thr_open_flag = 1'b0;
		end
		if (cmp_i.die_above_sd) begin
			s_d.tsd_flag = 1'b1;
		end
		if (cmp_i.die_above_warn) begin
			s_d.warn_flag = 1'b1;
		end
		if (sense_on && cmp_i.thr_open) begin
			s_d.thr_open_flag = 1'b1;
		end

		// ------------------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------------------
		if (reg_wr_i && (reg_addr_i == `CFBS_CTRL_ADDR)) begin
			s_d.thr_en = reg_wdata_i[`CFBS_CTRL_THR_EN_BIT];
		end
		if (reg_wr_i && (reg_addr_i == `CFBS_CFG2_ADDR)) begin
			s_d.zone_en = reg_wdata_i[`CFBS_CFG2_ZONE_EN_BIT];
			s_d.zone_sel = reg_wdata_i[`CFBS_CFG2_ZONE_SEL_BIT];
		end

		// ------------------------------------------------------------------------
		// Thermistor source switching
		// ------------------------------------------------------------------------
		if (sense_on) begin
			if (s_q.thr_cnt >= THR_CYCLES - 1) begin
				s_d.thr_cnt = 32'h0000_0000;
				s_d.thr_phase = ~s_q.thr_phase;
			end else begin
				s_d.thr_cnt = s_q.thr_cnt + 32'h0000_0001;
			end
		end else begin
			s_d.thr_cnt = 32'h0000_0000;
			s_d.thr_phase = 1'b0;
		end

		// ------------------------------------------------------------------------
		// Detection and charge sequence
		// ------------------------------------------------------------------------
		case (s_q.phase)
			cfbs_pkg::CFBS_IDLE: begin
				if (charge_request_i && cmp_i.supply_good && !s_q.tsd_flag
					&& cmp_i.die_below_sd_fall) begin
					s_d.phase = cfbs_pkg::CFBS_SINK;
					s_d.phase_cnt = 32'h0000_0000;
				end
			end
			cfbs_pkg::CFBS_SINK: begin
				if (s_q.phase_cnt >= DETECT_CYCLES - 1) begin
					s_d.phase_cnt = 32'h0000_0000;
					if (!cmp_i.bat_above_low_detect) begin
						s_d.phase = cfbs_pkg::CFBS_SOURCE;
					end else begin
						s_d.phase = cfbs_pkg::CFBS_FAST;
					end
				end
			end
			cfbs_pkg::CFBS_SOURCE: begin
				if (cmp_i.bat_above_high_detect) begin
					s_d.phase = cfbs_pkg::CFBS_NOBAT;
				end else if (s_q.phase_cnt >= DETECT_CYCLES - 1) begin
					s_d.phase_cnt = 32'h0000_0000;
					if (!cmp_i.bat_above_high_detect || !cmp_i.sense_above_high_detect) begin
						s_d.phase = cfbs_pkg::CFBS_TRICKLE;
						s_d.short_cnt = 32'h0000_0000;
						s_d.trk_cnt = 38'h00_0000_0000;
					end else begin
						s_d.phase = cfbs_pkg::CFBS_FAST;
					end
				end
			end
			cfbs_pkg::CFBS_TRICKLE: begin
				s_d.trk_cnt = s_q.trk_cnt + 38'h00_0000_0001;
				if (!s_q.short_flag) begin
					if (cmp_i.bat_above_short) begin
						s_d.short_cnt = 32'h0000_0000;
						if (cmp_i.bat_above_dead) begin
							s_d.phase = cfbs_pkg::CFBS_FAST;
						end
					end else if (s_q.short_cnt >= SHORT_CYCLES - 1) begin
						s_d.short_flag = 1'b1;
					end else begin
						s_d.short_cnt = s_q.short_cnt + 32'h0000_0001;
					end
				end
				if (64'(s_q.trk_cnt) >= TRICKLE_CYCLES - 1) begin
					s_d.phase = cfbs_pkg::CFBS_FAULT;
				end
			end
			cfbs_pkg::CFBS_FAST: begin
				if (!charge_request_i) begin
					s_d.phase = cfbs_pkg::CFBS_IDLE;
				end
			end
			cfbs_pkg::CFBS_FAULT: begin
				if (fault_clear) begin
					s_d.phase = cfbs_pkg::CFBS_IDLE;
				end
			end
			cfbs_pkg::CFBS_NOBAT: begin
				if (!charge_request_i) begin
					s_d.phase = cfbs_pkg::CFBS_IDLE;
				end
			end
			default: begin
				s_d.phase = cfbs_pkg::CFBS_IDLE;
			end
		endcase
		if (cmp_i.die_above_sd || (s_q.tsd_flag && charging)) begin
			s_d.phase = cfbs_pkg::CFBS_IDLE;
		end
		if (!cmp_i.supply_good && s_q.phase != cfbs_pkg::CFBS_FAULT) begin
			s_d.phase = cfbs_pkg::CFBS_IDLE;
		end

		// ------------------------------------------------------------------------
		// Outputs
		// ------------------------------------------------------------------------
		s_d.ctl.sink_en = (s_q.phase == cfbs_pkg::CFBS_SINK);
		s_d.ctl.source_en = (s_q.phase == cfbs_pkg::CFBS_SOURCE);
		s_d.ctl.trickle = (s_q.phase == cfbs_pkg::CFBS_TRICKLE);
		s_d.ctl.sys_at_trickle_level = s_q.short_flag;
		s_d.ctl.charge_en = charging && !s_q.tsd_flag && !cmp_i.die_above_sd
			&& !(s_q.zone_en && hot_cold)
			&& !(sense_on && cmp_i.thr_open);
		s_d.ctl.thr_source_on = sense_on && s_q.thr_phase;
		s_d.ctl.half_current = s_q.zone_en && sense_on && !s_q.zone_sel
			&& (zone == cfbs_pkg::CFBS_Z_COOL);
		s_d.ctl.vtrm_minus_100mv = s_q.zone_en && sense_on
			&& ((zone == cfbs_pkg::CFBS_Z_WARM)
			|| (s_q.zone_sel && zone == cfbs_pkg::CFBS_Z_COOL));

		// ------------------------------------------------------------------------
		// Isolation switch mode
		// ------------------------------------------------------------------------
		if (!cmp_i.supply_good) begin
			s_d.ctl.iso_mode = cfbs_pkg::CFBS_ISO_FULL;
		end else if (s_q.short_flag && s_q.phase == cfbs_pkg::CFBS_TRICKLE) begin
			s_d.ctl.iso_mode = cfbs_pkg::CFBS_ISO_OFF;
		end else if (cmp_i.sys_below_bat) begin
			s_d.ctl.iso_mode = cfbs_pkg::CFBS_ISO_FULL;
		end else if (s_q.phase == cfbs_pkg::CFBS_TRICKLE) begin
			s_d.ctl.iso_mode = cfbs_pkg::CFBS_ISO_OFF;
		end else if (s_q.zone_en && hot_cold && iso_base == cfbs_pkg::CFBS_ISO_OFF) begin
			s_d.ctl.iso_mode = cfbs_pkg::CFBS_ISO_REG;
		end else begin
			s_d.ctl.iso_mode = iso_base;
		end

		// ------------------------------------------------------------------------
		// Charger state code
		// ------------------------------------------------------------------------
		s_d.state_code = (s_q.phase == cfbs_pkg::CFBS_FAULT) ? `CFBS_CHG_FAULT_CODE
			: {1'b0, s_q.phase[1:0]};

		// ------------------------------------------------------------------------
		// Register reads
		// ------------------------------------------------------------------------
		if (reg_rd_i) begin
			case (reg_addr_i)
				`CFBS_FAULT_ADDR: begin
					s_d.rdata = {4'h0, s_q.thr_open_flag, s_q.short_flag, s_q.warn_flag, s_q.tsd_flag};
				end
				`CFBS_CTRL_ADDR: begin
					s_d.rdata = {3'h0, s_q.thr_en, 4'h0};
				end
				`CFBS_CFG2_ADDR: begin
					s_d.rdata = {s_q.zone_en, s_q.zone_sel, 6'h00};
				end
				`CFBS_STATUS_ADDR: begin
					s_d.rdata = {3'h0, zone, 2'h0} | {5'h00, s_q.state_code};
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.phase <= cfbs_pkg::CFBS_IDLE;
			s_q.zone_en <= ZONE_EN_PRESET;
			s_q.zone_sel <= ZONE_SEL_PRESET;
			s_q.ctl.iso_mode <= cfbs_pkg::CFBS_ISO_FULL;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o = s_q.rdata;
	assign ctl_o = s_q.ctl;
	assign charger_state_o = s_q.state_code;

endmodule : cfbs_supervisor

// ==== bench/cfbs_pack_model.sv ====
// Battery pack model: drives the battery-side comparator levels.
// Assumes sink and source enables from the supervisor and a pack mode from the bench.
`timescale 1ns/1ns
module cfbs_pack_model (
	input wire logic clk_i,
	input wire logic sink_en_i,
	input wire logic source_en_i,
	input wire logic [1:0] mode_i,
	output cfbs_pkg::cfbs_cmp_s cmp_o
);
	logic [1:0] up_q;

	// Empty socket: node climbs two cycles into a source phase
	always_ff @(posedge clk_i) begin
		up_q <= source_en_i ? {up_q[0], 1'b1} : 2'b00;
	end

	always_comb begin
		cmp_o = '0;
		case (mode_i)
			2'd0: begin
				// Charged cell holds every level
				cmp_o.bat_above_2v5 = 1'b1;
				cmp_o.bat_above_low_detect = 1'b1;
				cmp_o.bat_above_high_detect = 1'b1;
				cmp_o.sense_above_high_detect = 1'b1;
				cmp_o.bat_above_dead = 1'b1;
				cmp_o.bat_above_sys_reg = 1'b1;
				cmp_o.bat_above_short = 1'b1;
			end
			2'd1: begin
				// Sink pulls node low, source lifts it
				cmp_o.bat_above_low_detect = !sink_en_i && up_q[1];
				cmp_o.bat_above_high_detect = up_q[1];
			end
			default: begin
				// Shorted cell stays near ground
				cmp_o.bat_above_2v5 = 1'b0;
			end
		endcase
	end
endmodule : cfbs_pack_model

// ==== bench/cfbs_supervisor_assertions.sv ====
// Port checker for the charger supervisor.
// Assumes detect time 8 and thermistor interval 4 cycles; idle while ce_i is low.
`timescale 1ns/1ns
module cfbs_supervisor_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire cfbs_pkg::cfbs_cmp_s cmp_i,
	input wire cfbs_pkg::cfbs_ctl_s ctl_o,
	input wire logic [2:0] charger_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	chk_tsd_stop: assert property (cmp_i.die_above_sd |-> ##[1:2] !ctl_o.charge_en)
		else $error("charge on above shutdown");
	chk_nosup_full: assert property ((!cmp_i.supply_good)[*3]
		|-> ctl_o.iso_mode == cfbs_pkg::CFBS_ISO_FULL)
		else $error("switch not full without supply");
	chk_trk_off: assert property ((ctl_o.trickle && cmp_i.supply_good && !cmp_i.sys_below_bat)[*2]
		|-> ctl_o.iso_mode == cfbs_pkg::CFBS_ISO_OFF)
		else $error("switch on in trickle");
	chk_sag_full: assert property ((cmp_i.sys_below_bat && cmp_i.supply_good && !ctl_o.trickle)[*3]
		|-> ctl_o.iso_mode == cfbs_pkg::CFBS_ISO_FULL)
		else $error("switch not full on sag");
	chk_sink_len: assert property ($rose(ctl_o.sink_en)
		|-> ctl_o.sink_en[*7] ##[1:2] !ctl_o.sink_en)
		else $error("sink phase length");
	chk_short_iso: assert property (ctl_o.sys_at_trickle_level && cmp_i.supply_good
		&& !cmp_i.sys_below_bat |-> ctl_o.iso_mode == cfbs_pkg::CFBS_ISO_OFF)
		else $error("switch on after short");
	chk_thr_gap: assert property ($rose(ctl_o.thr_source_on) && cmp_i.supply_in_range
		|-> ctl_o.thr_source_on[*3] ##[1:2] !ctl_o.thr_source_on)
		else $error("thermistor interval");
	chk_thr_off: assert property ((!cmp_i.supply_in_range && !cmp_i.bat_above_2v5)[*3]
		|-> !ctl_o.thr_source_on)
		else $error("thermistor on at low cell");
	chk_open_cold: assert property (cmp_i.thr_open && cmp_i.supply_in_range
		|-> ##[1:2] !ctl_o.charge_en)
		else $error("charge with open thermistor");

	cov_sink: cover property ($rose(ctl_o.sink_en));
	cov_trickle: cover property ($rose(ctl_o.trickle));
	cov_fault: cover property (charger_state_o == 3'h6);
endmodule : cfbs_supervisor_assertions

bind cfbs_supervisor cfbs_supervisor_assertions i_cfbs_supervisor_assertions (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.cmp_i(cmp_i),
	.ctl_o(ctl_o),
	.charger_state_o(charger_state_o)
);

// ==== bench/cfbs_supervisor_bench.sv ====
// Self-checking bench for the charger supervisor.
// Assumes the pack model beside it and the checker bound to the design.
`timescale 1ns/1ns
module cfbs_supervisor_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic req = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] v;
	logic [1:0] mode = 2'd0;
	logic [2:0] state;
	cfbs_pkg::cfbs_cmp_s env = '0;
	cfbs_pkg::cfbs_cmp_s pk;
	cfbs_pkg::cfbs_cmp_s cmp;
	cfbs_pkg::cfbs_ctl_s ctl;
	int n_fail = 0;
	int samples_checked = 0;
	logic [3:0] zin [7] = '{4'h4, 4'h0, 4'h4, 4'h2, 4'h4, 4'hC, 4'h3};
	logic [2:0] zex [7] = '{3'h4, 3'h4, 3'h6, 3'h5, 3'h5, 3'h0, 3'h0};

	assign cmp = pk | env;

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	cfbs_pack_model i_cfbs_pack_model (
		.clk_i(clk_i),
		.sink_en_i(ctl.sink_en),
		.source_en_i(ctl.source_en),
		.mode_i(mode),
		.cmp_o(pk)
	);

	cfbs_supervisor #(
		.DETECT_CYCLES(8),
		.SHORT_CYCLES(16),
		.THR_CYCLES(4),
		.TRICKLE_CYCLES(64)
	) i_cfbs_supervisor (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce),
		.charge_request_i(req),
		.cmp_i(cmp),
		.reg_addr_i(addr),
		.reg_wr_i(wr),
		.reg_wdata_i(wdata),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.ctl_o(ctl),
		.charger_state_o(state)
	);

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task end_sim;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr = a;
		rd = 1'b1;
		@(negedge clk_i);
		rd = 1'b0;
		d = rdata;
	endtask : rd_reg

	task poll(input int sel);
		for (int i = 0; i < 400; i++) begin
			@(negedge clk_i);
			if (sel == 0 && ctl.charge_en === 1'b1) return;
			if (sel == 1 && ctl.trickle === 1'b1) return;
			if (sel == 2 && state === 3'h6) return;
			if (sel == 3 && ctl.source_en === 1'b1) return;
			if (sel == 4 && ctl.thr_source_on === 1'b1) return;
		end
		n_fail++;
		$display("[FAIL] wait %0d expected 1 seen 0", sel);
		end_sim();
	endtask : poll

	task boot(input logic [1:0] m);
		@(negedge clk_i);
		rst_i = 1'b1;
		req = 1'b0;
		mode = m;
		cyc(2);
		rst_i = 1'b0;
	endtask : boot

	// ------------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------------
	initial begin
		env.supply_good = 1'b1;
		env.supply_in_range = 1'b1;
		env.die_below_sd_fall = 1'b1;
		boot(2'd0);
		rd_reg(8'h07, v);
		chk("ctrl_rst", 8'h00, v & 8'h10);
		ce = 1'b0;
		wr_reg(8'h07, 8'h10);
		ce = 1'b1;
		rd_reg(8'h07, v);
		chk("ce_hold", 8'h00, v & 8'h10);
		rd_reg(8'h20, v);
		chk("unmapped", 8'h00, v);
		env.die_above_warn = 1'b1;
		cyc(2);
		rd_reg(8'h0D, v);
		chk("warn_flag", 8'h02, v & 8'h02);
		env.die_above_warn = 1'b0;
		wr_reg(8'h0D, 8'h02);
		rd_reg(8'h0D, v);
		chk("warn_clr", 8'h00, v & 8'h02);
		req = 1'b1;
		poll(0);
		chk("iso_fast", 8'(cfbs_pkg::CFBS_ISO_FULL), 8'(ctl.iso_mode));
		env.sys_below_bat = 1'b1;
		cyc(3);
		chk("iso_sag", 8'(cfbs_pkg::CFBS_ISO_FULL), 8'(ctl.iso_mode));
		env.sys_below_bat = 1'b0;
		for (int k = 0; k < 7; k++) begin
			if (k == 1) wr_reg(8'h08, 8'h80);
			if (k == 4) wr_reg(8'h08, 8'hC0);
			{env.thr_below_0c, env.thr_below_10c, env.thr_above_45c, env.thr_above_60c} = zin[k];
			cyc(3);
			v = 8'({ctl.charge_en, ctl.half_current, ctl.vtrm_minus_100mv});
			if (k > 4) v = v & 8'h04;
			chk("zone", 8'(zex[k]), v);
		end
		env.thr_above_45c = 1'b0;
		env.thr_above_60c = 1'b0;
		wr_reg(8'h08, 8'h00);
		env.thr_open = 1'b1;
		cyc(3);
		chk("open_chg", 8'h00, 8'(ctl.charge_en));
		rd_reg(8'h0D, v);
		chk("open_flag", 8'h08, v & 8'h08);
		env.thr_open = 1'b0;
		boot(2'd0);
		req = 1'b1;
		poll(0);
		env.die_above_sd = 1'b1;
		env.die_below_sd_fall = 1'b0;
		cyc(3);
		chk("tsd_chg", 8'h00, 8'(ctl.charge_en));
		rd_reg(8'h0D, v);
		chk("tsd_flag", 8'h01, v & 8'h01);
		env.die_above_sd = 1'b0;
		cyc(20);
		chk("tsd_hold", 8'h00, 8'(ctl.charge_en));
		wr_reg(8'h0D, 8'h01);
		rd_reg(8'h0D, v);
		chk("tsd_clr", 8'h00, v & 8'h01);
		cyc(20);
		chk("tsd_warm", 8'h00, 8'(ctl.charge_en));
		env.die_below_sd_fall = 1'b1;
		poll(0);
		boot(2'd1);
		req = 1'b1;
		poll(3);
		cyc(20);
		chk("absent", 8'h00, 8'({ctl.charge_en, ctl.trickle}));
		boot(2'd2);
		req = 1'b1;
		poll(1);
		chk("trk_iso", 8'(cfbs_pkg::CFBS_ISO_OFF), 8'(ctl.iso_mode));
		env.sys_below_bat = 1'b1;
		cyc(3);
		chk("iso_sag_trk", 8'(cfbs_pkg::CFBS_ISO_FULL), 8'(ctl.iso_mode));
		env.sys_below_bat = 1'b0;
		cyc(20);
		rd_reg(8'h0D, v);
		chk("short_flag", 8'h04, v & 8'h04);
		chk("short_sys", 8'h03, 8'({ctl.trickle, ctl.sys_at_trickle_level}));
		poll(2);
		wr_reg(8'h0D, 8'hFF);
		cyc(2);
		chk("fault_exit", 8'h00, 8'(state == 3'h6));
		env.supply_good = 1'b0;
		env.supply_in_range = 1'b0;
		boot(2'd2);
		cyc(12);
		chk("thr_low", 8'h00, 8'(ctl.thr_source_on));
		chk("iso_nosup", 8'(cfbs_pkg::CFBS_ISO_FULL), 8'(ctl.iso_mode));
		mode = 2'd0;
		wr_reg(8'h07, 8'h10);
		poll(4);
		end_sim();
	end
endmodule : cfbs_supervisor_bench
